/* hdl/rtcd_calendar.sv */
// Weekday, day-of-month and month counters with an APB register port.
// Assumes the daily carry is a one-cycle pulse from the hour counter and
// the leap-year level comes from the year counter logic.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
module rtcd_calendar #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              day_carry,
  input  wire logic              leap_year,
  output logic                   year_carry
);

  // Counter contents, deliberately without reset
  logic [rtcd_pkg::WK_W-1:0]  wk_reg;
  logic [rtcd_pkg::DAY_W-1:0] day_reg;
  logic [rtcd_pkg::MON_W-1:0] mon_reg;

  // Bus answer flops and the yearly carry flop
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        year_carry_reg;

  logic [7:0]  addr8;
  logic        sel_wk;
  logic        sel_day;
  logic        sel_mon;
  logic        mapped;
  logic        wr_ok;
  logic        wr_wk;
  logic        wr_day;
  logic        wr_mon;
  logic [rtcd_pkg::DAY_W-1:0] last_day;
  logic        day_wrap;
  logic        mon_wrap;
  logic        mon_step;
  logic [2:0]  loaded_reg;

  // BCD increment of an 8-bit pair of digits
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    if (v[3:0] >= rtcd_pkg::BCD_NINE) begin
      r = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      r = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction

  // Address decode; only the low byte of the address matters
  assign addr8   = 8'(paddr);
  assign sel_wk  = (addr8 == rtcd_pkg::OFS_WEEKDAY);
  assign sel_day = (addr8 == rtcd_pkg::OFS_DAY);
  assign sel_mon = (addr8 == rtcd_pkg::OFS_MONTH);
  assign mapped  = sel_wk | sel_day | sel_mon;

  // Write lands at the access edge; lane 0 carries all counter bits
  assign wr_ok  = psel & penable & pready_reg & pwrite & pstrb[0];
  assign wr_wk  = wr_ok & sel_wk;
  assign wr_day = wr_ok & sel_day;
  assign wr_mon = wr_ok & sel_mon;

  // Month length; BCD order matches numeric order so compares work
  always_comb begin
    last_day = rtcd_pkg::DAY_31;
    if (mon_reg == rtcd_pkg::MON_FEB) begin
      last_day = leap_year ? rtcd_pkg::DAY_29 : rtcd_pkg::DAY_28;
    end else if (mon_reg == rtcd_pkg::MON_APR ||
                 mon_reg == rtcd_pkg::MON_JUN ||
                 mon_reg == rtcd_pkg::MON_SEP ||
                 mon_reg == rtcd_pkg::MON_NOV) begin
      last_day = rtcd_pkg::DAY_30;
    end
  end

  // Out-of-range loads still wrap rather than run away
  assign day_wrap = (day_reg >= last_day);
  assign mon_wrap = (mon_reg >= rtcd_pkg::MON_LAST);
  assign mon_step = day_carry & day_wrap;

  // Weekday counter; a bus write wins over a same-cycle step
  always_ff @(posedge clk_sys) begin
    if (wr_wk) begin
      wk_reg <= pwdata[rtcd_pkg::WK_W-1:0];
    end else if (day_carry) begin
      if (wk_reg >= rtcd_pkg::WK_LAST) begin
        wk_reg <= rtcd_pkg::WK_FIRST;
      end else begin
        wk_reg <= wk_reg + 3'h1;
      end
    end
  end

  // Day counter, no reset so contents survive any reset
  always_ff @(posedge clk_sys) begin
    if (wr_day) begin
      day_reg <= pwdata[rtcd_pkg::DAY_W-1:0];
    end else if (day_carry) begin
      if (day_wrap) begin
        day_reg <= rtcd_pkg::DAY_FIRST;
      end else begin
        day_reg <= 6'(bcd_inc({2'b00, day_reg}));
      end
    end
  end

  // Month counter steps on the month carry from the day counter
  always_ff @(posedge clk_sys) begin
    if (wr_mon) begin
      mon_reg <= pwdata[rtcd_pkg::MON_W-1:0];
    end else if (mon_step) begin
      if (mon_wrap) begin
        mon_reg <= rtcd_pkg::MON_FIRST;
      end else begin
        mon_reg <= 5'(bcd_inc({3'b000, mon_reg}));
      end
    end
  end

  // Yearly carry pulse to the year counter, one cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      year_carry_reg <= 1'b0;
    end else begin
      year_carry_reg <= mon_step & mon_wrap;
    end
  end

  // Load tracking, used by the checks only. It has no reset, like the
  // counters, so it outlives rstn. In four-state simulation it starts
  // unknown; a write ORs in a settled one, so the hold check stays quiet
  // until software has loaded all three counters once.
  always_ff @(posedge clk_sys) begin
    loaded_reg <= loaded_reg | {wr_mon, wr_day, wr_wk};
  end

  // Bus answer: data captured in setup, ready for one access cycle.
  // Zero wait states keep the read and the write one edge apart only.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_reg  <= rtcd_pkg::RDATA_IDLE;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !mapped;
      prdata_reg  <= rtcd_pkg::RDATA_IDLE;
      if (!pwrite) begin
        if (sel_wk) begin
          prdata_reg <= {29'h0, wk_reg};
        end else if (sel_day) begin
          prdata_reg <= {26'h0, day_reg};
        end else if (sel_mon) begin
          prdata_reg <= {27'h0, mon_reg};
        end
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= rtcd_pkg::RDATA_IDLE;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign year_carry = year_carry_reg;

  // Checks on the counters and the bus. Reset gates them all, but the
  // counters keep their contents through reset, so the hold check leans
  // on the load tracking above rather than on rstn.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  wk_step_a: assert property (
    day_carry && !wr_wk && wk_reg < rtcd_pkg::WK_LAST
    |=> wk_reg == $past(wk_reg) + 3'h1)
    else $error("weekday did not step on daily carry");

  wk_wrap_a: assert property (
    day_carry && !wr_wk && wk_reg == rtcd_pkg::WK_LAST
    |=> wk_reg == rtcd_pkg::WK_FIRST)
    else $error("weekday did not wrap to Sunday");

  wk_read_a: assert property (
    psel && !penable && !pwrite && sel_wk
    |=> pready && prdata[31:3] == 29'h0 && prdata[2:0] == $past(wk_reg))
    else $error("weekday read data wrong");

  day_step_a: assert property (
    day_carry && !wr_day && !day_wrap && day_reg[3:0] < 4'h9
    |=> day_reg == $past(day_reg) + 6'h01)
    else $error("day did not step on daily carry");

  day_tens_a: assert property (
    day_carry && !wr_day && !day_wrap && day_reg[3:0] == 4'h9
    |=> day_reg[3:0] == 4'h0 && day_reg[5:4] == $past(day_reg[5:4]) + 2'h1)
    else $error("day units did not roll into tens");

  day_wrap_a: assert property (
    day_carry && !wr_day && day_reg == 6'h28 && mon_reg == 5'h02
    && !leap_year |=> day_reg == 6'h01)
    else $error("day did not wrap after last day of February");

  day_read_a: assert property (
    psel && !penable && !pwrite && sel_day
    |=> prdata[31:6] == 26'h0 && prdata[5:0] == $past(day_reg))
    else $error("day read data wrong");

  mon_step_a: assert property (
    day_carry && day_wrap && !wr_mon && mon_reg == 5'h09
    |=> mon_reg == 5'h10)
    else $error("month did not carry into tens");

  mon_read_a: assert property (
    psel && !penable && !pwrite && sel_mon
    |=> prdata[31:5] == 27'h0 && prdata[4:0] == $past(mon_reg))
    else $error("month read data wrong");

  yr_carry_a: assert property (
    day_carry && day_wrap && mon_reg == 5'h12
    |=> year_carry ##1 !year_carry)
    else $error("year carry missing or too long");

  hold_a: assert property (
    &loaded_reg && !day_carry && !wr_ok
    |=> $stable(wk_reg) && $stable(day_reg) && $stable(mon_reg))
    else $error("counter changed without carry or write");

  // Landed writes show next cycle, reserved bits dropped
  wk_write_a: assert property (
    wr_wk |=> wk_reg == $past(pwdata[2:0]))
    else $error("weekday write did not land");

  day_write_a: assert property (
    wr_day |=> day_reg == $past(pwdata[5:0]))
    else $error("day write did not land");

  mon_write_a: assert property (
    wr_mon |=> mon_reg == $past(pwdata[4:0]))
    else $error("month write did not land");

  wk_wr_carry_a: assert property (
    day_carry && wr_day && !wr_wk && wk_reg == 3'h6
    |=> wk_reg == 3'h0)
    else $error("weekday missed a step during a day write");

  // Valid contents stay valid across a step
  wk_range_a: assert property (
    day_carry && !wr_wk && wk_reg <= rtcd_pkg::WK_LAST
    |=> wk_reg <= rtcd_pkg::WK_LAST)
    else $error("weekday left the range 0 to 6");

  day_range_a: assert property (
    day_carry && !wr_day && day_reg >= 6'h01 && day_reg <= last_day
    && day_reg[3:0] <= 4'h9
    |=> day_reg >= 6'h01 && day_reg <= 6'h31 && day_reg[3:0] <= 4'h9)
    else $error("day left the range 01 to 31");

  mon_range_a: assert property (
    mon_step && !wr_mon && mon_reg >= 5'h01 && mon_reg <= 5'h12
    && mon_reg[3:0] <= 4'h9
    |=> mon_reg >= 5'h01 && mon_reg <= 5'h12 && mon_reg[3:0] <= 4'h9)
    else $error("month left the range 01 to 12");

  // Month ends by month length and leap year
  leap_day_a: assert property (
    day_carry && !wr_day && day_reg == 6'h28 && mon_reg == 5'h02
    && leap_year |=> day_reg == 6'h29)
    else $error("day did not reach 29 in a leap February");

  feb_leap_a: assert property (
    day_carry && !wr_day && day_reg == 6'h29 && mon_reg == 5'h02
    && leap_year |=> day_reg == 6'h01)
    else $error("day did not wrap after 29 in a leap February");

  apr_end_a: assert property (
    day_carry && !wr_day && day_reg == 6'h30 && mon_reg == 5'h04
    |=> day_reg == 6'h01)
    else $error("day did not wrap after 30 in April");

  sep_end_a: assert property (
    day_carry && !wr_day && day_reg == 6'h30 && mon_reg == 5'h09
    |=> day_reg == 6'h01)
    else $error("day did not wrap after 30 in September");

  long_month_a: assert property (
    day_carry && !wr_day && day_reg == 6'h30 && mon_reg == 5'h01
    |=> day_reg == 6'h31)
    else $error("day wrapped early in a long month");

  long_end_a: assert property (
    day_carry && !wr_day && day_reg == 6'h31 |=> day_reg == 6'h01)
    else $error("day did not wrap after 31");

  // Month carry only at the end of a month
  mon_wrap_a: assert property (
    day_carry && !wr_mon && day_reg == 6'h31 && mon_reg == 5'h12
    |=> mon_reg == 5'h01)
    else $error("month did not wrap from 12 to 01");

  mon_quiet_a: assert property (
    day_carry && !wr_mon && day_reg < 6'h28 |=> $stable(mon_reg))
    else $error("month stepped although the day did not wrap");

  mon_feb_a: assert property (
    day_carry && !wr_mon && day_reg == 6'h29 && mon_reg == 5'h02
    && leap_year |=> mon_reg == 5'h03)
    else $error("month did not leave a leap February");

  mon_apr_a: assert property (
    day_carry && !wr_mon && day_reg == 6'h30 && mon_reg == 5'h04
    |=> mon_reg == 5'h05)
    else $error("month did not leave April");

  // Yearly carry follows the December month carry and nothing else
  yr_cause_a: assert property (
    year_carry |-> $past(day_carry) && $past(mon_reg) == 5'h12)
    else $error("year carry without a December month carry");

  yr_mon_a: assert property (
    year_carry && !$past(wr_mon) |-> mon_reg == 5'h01)
    else $error("month not back at 01 with the year carry");

  // Main scenarios: year end, leap day, a write meeting a step, a bus
  // error and the month tens carry
  yr_end_c: cover property (day_carry && day_wrap && mon_wrap);
  leap_c: cover property (day_carry && leap_year && day_reg == 6'h29);
  wr_step_c: cover property (wr_day && day_carry);
  err_c: cover property (pready && pslverr);
  mon_tens_c: cover property (mon_step && mon_reg == 5'h09);

endmodule

/* common/rtcd_pkg.sv */
// Constants for the calendar counters: register map, field layout, BCD
// limits and bus answer values.
// Assumes a 32-bit APB register bus and BCD-coded counter contents.
// Overview of operation
// - Weekday is 3 bits in the low bits, 0 Sunday up to 6 Saturday.
// - Weekday steps by one on each daily carry from the hour counter.
// - Weekday bits 3 to 7 read zero, ignore writes; software writes zero.
// - Day is BCD, units bits 0-3, tens bits 4-5, range 01 to 31.
// - Day increments on the daily carry from the hour counter.
// - Day bits 6 and 7 read zero, ignore writes; software writes zero.
// - Month is BCD, units bits 0-3, tens bit 4, steps on month carry.
// - Month bits 5 to 7 read zero, ignore writes; software writes zero.
// - Counters keep contents across resets; undefined after power-up.
// - Month counter issues a yearly carry that advances the year counter.
package rtcd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_WEEKDAY = 8'h10;
  localparam logic [7:0] OFS_DAY     = 8'h14;
  localparam logic [7:0] OFS_MONTH   = 8'h18;

  // Field widths
  localparam int WK_W  = 3;
  localparam int DAY_W = 6;
  localparam int MON_W = 5;

  // Counter limits, BCD coded
  localparam logic [2:0] WK_LAST    = 3'h6;
  localparam logic [2:0] WK_FIRST   = 3'h0;
  localparam logic [5:0] DAY_FIRST  = 6'h01;
  localparam logic [5:0] DAY_31     = 6'h31;
  localparam logic [5:0] DAY_30     = 6'h30;
  localparam logic [5:0] DAY_29     = 6'h29;
  localparam logic [5:0] DAY_28     = 6'h28;
  localparam logic [4:0] MON_FIRST  = 5'h01;
  localparam logic [4:0] MON_LAST   = 5'h12;
  localparam logic [4:0] MON_FEB    = 5'h02;
  localparam logic [4:0] MON_APR    = 5'h04;
  localparam logic [4:0] MON_JUN    = 5'h06;
  localparam logic [4:0] MON_SEP    = 5'h09;
  localparam logic [4:0] MON_NOV    = 5'h11;

  // BCD digit top value
  localparam logic [3:0] BCD_NINE   = 4'h9;

  // Bus answer values
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

endpackage

/* testbench/rtcd_calendar_test.sv */
// Self-checking bench for the calendar counters: APB access and day steps.
// Assumes the design answers each APB access and pulses year_carry once.
`timescale 1ns/1ns
module rtcd_calendar_test;
  logic        clk_sys;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        day_carry;
  logic        leap_year;
  logic        year_carry;
  int          error_cnt;
  int          cmp_count;
  int          yc_cnt = 0;

  rtcd_calendar dut (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .day_carry  (day_carry),
    .leap_year  (leap_year),
    .year_carry (year_carry)
  );

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // Count yearly pulses; a level stuck high shows up as extra counts
  always @(posedge clk_sys) begin
    if (year_carry === 1'b1) yc_cnt++;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      error_cnt++;
      $display("Error pready expected 1 seen timeout");
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, 4'hF, rd, er);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, 4'hF, rd, er);
    chk(nm, e, rd);
    chk({nm, " slverr"}, 32'h0, {31'h0, er});
  endtask

  // Load a date, give one daily carry, read back all three counters
  task automatic step(input logic [2:0] w, input logic [5:0] dy,
                      input logic [4:0] mo, input logic lp,
                      input logic [2:0] ew, input logic [5:0] ed,
                      input logic [4:0] em, input logic ey);
    int y0;
    wr(rtcd_pkg::OFS_WEEKDAY, {29'h0, w});
    wr(rtcd_pkg::OFS_DAY, {26'h0, dy});
    wr(rtcd_pkg::OFS_MONTH, {27'h0, mo});
    leap_year <= lp;
    y0 = yc_cnt;
    @(posedge clk_sys);
    day_carry <= 1'b1;
    @(posedge clk_sys);
    day_carry <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd_chk("weekday", rtcd_pkg::OFS_WEEKDAY, {29'h0, ew});
    rd_chk("day", rtcd_pkg::OFS_DAY, {26'h0, ed});
    rd_chk("month", rtcd_pkg::OFS_MONTH, {27'h0, em});
    chk("year_carry pulses", {31'h0, ey}, 32'(yc_cnt - y0));
  endtask

  // Main sequence
  initial begin
    logic [31:0] rd;
    logic        er;
    {clk_sys, rstn, psel, penable, pwrite, day_carry, leap_year} = '0;
    {paddr, pwdata, pstrb, error_cnt, cmp_count} = '0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    // Reserved bits written as ones must read back zero
    wr(rtcd_pkg::OFS_WEEKDAY, 32'hFFFF_FFFD);
    wr(rtcd_pkg::OFS_DAY, 32'hFFFF_FFE8);
    wr(rtcd_pkg::OFS_MONTH, 32'hFFFF_FFF1);
    rd_chk("weekday", rtcd_pkg::OFS_WEEKDAY, 32'h0000_0005);
    rd_chk("day", rtcd_pkg::OFS_DAY, 32'h0000_0028);
    rd_chk("month", rtcd_pkg::OFS_MONTH, 32'h0000_0011);
    // Byte lane zero off and unmapped places leave counters alone
    apb(1'b1, rtcd_pkg::OFS_DAY, 32'h0000_0003, 4'h0, rd, er);
    apb(1'b1, 8'h1C, 32'h0000_0002, 4'hF, rd, er);
    chk("unmapped write slverr", 32'h1, {31'h0, er});
    apb(1'b0, 8'h1C, 32'h0, 4'hF, rd, er);
    chk("unmapped read slverr", 32'h1, {31'h0, er});
    chk("unmapped read data", 32'h0, rd);
    rd_chk("day", rtcd_pkg::OFS_DAY, 32'h0000_0028);
    $display("Register access test done");
    // Counters survive a reset in mid-run
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk("weekday", rtcd_pkg::OFS_WEEKDAY, 32'h0000_0005);
    rd_chk("day", rtcd_pkg::OFS_DAY, 32'h0000_0028);
    rd_chk("month", rtcd_pkg::OFS_MONTH, 32'h0000_0011);
    $display("Reset retention test done");
    // Daily carry: wraps, digit roll, month ends and year end
    step(3'h6, 6'h09, 5'h01, 1'b0, 3'h0, 6'h10, 5'h01, 1'b0);
    step(3'h2, 6'h28, 5'h02, 1'b1, 3'h3, 6'h29, 5'h02, 1'b0);
    step(3'h1, 6'h29, 5'h02, 1'b1, 3'h2, 6'h01, 5'h03, 1'b0);
    step(3'h3, 6'h28, 5'h02, 1'b0, 3'h4, 6'h01, 5'h03, 1'b0);
    step(3'h4, 6'h30, 5'h04, 1'b0, 3'h5, 6'h01, 5'h05, 1'b0);
    step(3'h0, 6'h30, 5'h01, 1'b0, 3'h1, 6'h31, 5'h01, 1'b0);
    step(3'h5, 6'h30, 5'h09, 1'b0, 3'h6, 6'h01, 5'h10, 1'b0);
    step(3'h5, 6'h31, 5'h12, 1'b0, 3'h6, 6'h01, 5'h01, 1'b1);
    $display("Daily carry test done");
    // A day write meeting a daily carry wins; the weekday still steps
    fork
      wr(rtcd_pkg::OFS_DAY, 32'h0000_0015);
      begin
        repeat (2) @(posedge clk_sys);
        day_carry <= 1'b1;
        @(posedge clk_sys);
        day_carry <= 1'b0;
      end
    join
    rd_chk("weekday", rtcd_pkg::OFS_WEEKDAY, 32'h0000_0000);
    rd_chk("day", rtcd_pkg::OFS_DAY, 32'h0000_0015);
    rd_chk("month", rtcd_pkg::OFS_MONTH, 32'h0000_0001);
    $display("Write against carry test done");
    final_report();
  end
endmodule
